// ---- rtl/dcs_pkg.sv ----
// shared constants and types of the disk status and format block
package dcs_pkg;
  // ==========================================================
  // clock and byte timing
  localparam int CLK_MHZ = 25;
  localparam int BYTE_NS_FM = 32000;
  localparam int BYTE_NS_MFM = 16000;
  localparam int BYTE_CYC_FM = BYTE_NS_FM * CLK_MHZ / 1000;
  localparam int BYTE_CYC_MFM = BYTE_NS_MFM * CLK_MHZ / 1000;
  // ==========================================================
  // register map
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // ==========================================================
  // command codes (upper nibble)
  localparam logic [3:0] CMD_ABORT = 4'hd;
  localparam logic [3:0] CMD_RD_ADDR = 4'hc;
  localparam logic [3:0] CMD_RD_TRK = 4'he;
  localparam logic [3:0] CMD_WR_TRK = 4'hf;
  localparam int CMD_XFER_BIT = 7;
  localparam int CMD_WSEC_BIT = 5;
  localparam int CMD_HLOAD_BIT = 3;
  localparam int CMD_VERIFY_BIT = 2;
  // abort condition field bits
  localparam int AB_TO_READY = 0;
  localparam int AB_TO_NRDY = 1;
  localparam int AB_INDEX = 2;
  localparam int AB_IMM = 3;
  // ==========================================================
  // track writing codes and patterns
  localparam logic [7:0] TB_A1M = 8'hf5;
  localparam logic [7:0] TB_C2M = 8'hf6;
  localparam logic [7:0] TB_CRC = 8'hf7;
  localparam logic [7:0] TB_DAM_LO = 8'hf8;
  localparam logic [7:0] TB_DAM_HI = 8'hfb;
  localparam logic [7:0] TB_IXM = 8'hfc;
  localparam logic [7:0] TB_IDAM = 8'hfe;
  localparam logic [7:0] MARK_A1 = 8'ha1;
  localparam logic [7:0] MARK_C2 = 8'hc2;
  localparam logic [7:0] CLK_NORM = 8'hff;
  localparam logic [7:0] CLK_AM = 8'hc7;
  localparam logic [7:0] CLK_IX = 8'hd7;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // status layout class
  typedef enum logic [2:0] {
    CLS_POS = 3'h0, CLS_RADDR = 3'h1, CLS_RSEC = 3'h2,
    CLS_RTRK = 3'h3, CLS_WSEC = 3'h4, CLS_WTRK = 3'h5
  } dcs_cls_e;
endpackage

// ---- rtl/dcs_enc_if.sv ----
// byte hand-off between the control logic and the track encoder
`timescale 1ns/10ps
interface dcs_enc_if;
  logic stb; // one byte slot
  logic fm; // fm recording when high
  logic crc_lo; // emit low crc byte this slot
  logic [7:0] raw; // byte taken from the holding register
  logic [7:0] wdat; // encoded data byte
  logic [7:0] wclk; // fm clock pattern
  logic miss; // mfm mark with a missing clock
  modport enc (input stb, fm, crc_lo, raw, output wdat, wclk, miss);
  modport ctl (output stb, fm, crc_lo, raw, input wdat, wclk, miss);
endinterface

// ---- rtl/dcs_trk_enc.sv ----
// track encoder: control byte translation and crc generation
`timescale 1ns/10ps
module dcs_trk_enc (
  input wire logic i_mclk, // system clock
  input wire logic i_rst, // sync reset, high
  dcs_enc_if.enc e // byte slot port
);
  import dcs_pkg::*;

  logic [15:0] crc;

  // crc-16 over one byte, msb first
  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // byte translation per slot
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crc <= CRC_PRESET;
      e.wdat <= FILL_BYTE;
      e.wclk <= CLK_NORM;
      e.miss <= 1'b0;
    end else if (e.stb) begin
      e.wclk <= CLK_NORM;
      e.miss <= 1'b0;
      e.wdat <= e.raw;
      if (e.crc_lo) begin
        e.wdat <= crc[7:0];
      end else if (e.raw == TB_CRC) begin
        e.wdat <= crc[15:8];
      end else if (!e.fm && e.raw == TB_A1M) begin
        e.wdat <= MARK_A1;
        e.miss <= 1'b1;
        crc <= crc_upd(CRC_PRESET, MARK_A1);
      end else if (!e.fm && e.raw == TB_C2M) begin
        e.wdat <= MARK_C2;
        e.miss <= 1'b1;
        crc <= crc_upd(crc, MARK_C2);
      end else if (e.fm && (e.raw == TB_IDAM ||
                   (e.raw >= TB_DAM_LO && e.raw <= TB_DAM_HI))) begin
        e.wclk <= CLK_AM;
        crc <= crc_upd(CRC_PRESET, e.raw);
      end else begin
        if (e.fm && e.raw == TB_IXM) begin
          e.wclk <= CLK_IX;
        end
        crc <= crc_upd(crc, e.raw);
      end
    end
  end
endmodule

// ---- rtl/dcs_ctrl.sv ----
// command, status, abort and track-writing logic of the disk controller
// Behaviour
// - abort taken anytime; ends running command, interrupts on chosen condition
// - condition bits: to-ready, to-not-ready, each index, immediate
// - zero condition field ends command, clears busy, no interrupt
// - immediate interrupt stays pending until a later abort
// - other commands refresh all other status bits; only accepted ones set busy
// - abort while running clears busy, keeps other status bits
// - abort while idle clears busy, refreshes, shows positioning layout
// - positioning layout: nrdy, wp, head, seek, crc, trk0, index, busy
// - transfer layout: nrdy, wp, type/fault, rnf, crc, lost, drq, busy
// - not-ready bit is inverted ready ORed with reset
// - transfer commands refused while drive not ready
// - positioning write-protect bit is inverted protect input
// - head-loaded bit is head load AND head settle
// - seek error set on failed verify, cleared on update
// - track-zero and index bits are inverted inputs
// - crc error bit flags id or data fault, cleared on update
// - lost data set when request not served in a byte time
// - request status bit mirrors request output, cleared on update
// - write track requests at once, one request per written byte
// - bytes f5..fe are control codes; fm fe writes c7-clocked mark
// - f7 appends two computed crc bytes in both densities
// - mfm f5 writes a1 missing clock with preset, f6 writes c2
// - empty holding register at byte time writes a zero byte
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module dcs_ctrl #(
  parameter int BYTE_CYC_FM = dcs_pkg::BYTE_CYC_FM, // fm byte time
  parameter int BYTE_CYC_MFM = dcs_pkg::BYTE_CYC_MFM // mfm byte time
) (
  input wire logic i_mclk, // 25 mhz clock
  input wire logic i_rst, // sync reset, high
  input wire logic [dcs_pkg::ADDR_W-1:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  input wire logic i_ready, // drive ready, high
  input wire logic i_write_protect_input_n, // protect, low
  input wire logic i_head_settle_input, // head settled, high
  input wire logic i_track_zero_input_n, // track zero, low
  input wire logic i_index_pulse_input_n, // index pulse, low
  input wire logic i_density_select, // 1 fm, 0 mfm
  input wire logic i_crc_fault, // crc fault pulse from read path
  input wire logic i_write_fault, // drive write fault
  output logic o_intrq, // interrupt request
  output logic o_byte_transfer_request, // byte request
  output logic o_head_load_output, // head load
  output logic o_write_gate, // write gate
  output logic o_wr_strobe, // encoded byte valid
  output logic [7:0] o_wr_data, // encoded data byte
  output logic [7:0] o_wr_clk, // fm clock pattern
  output logic o_wr_miss // mfm missing clock mark
);
  import dcs_pkg::*;

  localparam int CNT_W = $clog2(BYTE_CYC_FM + 1);

  generate
    if (BYTE_CYC_FM < 2 || BYTE_CYC_MFM < 2 ||
        BYTE_CYC_MFM > BYTE_CYC_FM) begin : g_bad
      $error("byte time parameters out of range");
    end
  endgenerate

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_POS = 5'b00010,
    S_XFER = 5'b00100,
    S_WT_WAIT = 5'b01000,
    S_WT_RUN = 5'b10000
  } dcs_state_e;

  dcs_state_e state;
  dcs_cls_e cls;
  dcs_enc_if enc ();

  logic idx_prev_n, rdy_prev, idx_seen, pos_verify;
  logic seek_err, crc_err, rnf, lost, wfault, wp_lat;
  logic imm_pend, crc_lo_next, dr_full;
  logic [2:0] arm;
  logic [7:0] dr, status_now;
  logic [CNT_W-1:0] byte_cnt;
  logic idx_edge, rdy_rise, rdy_fall, busy, nrdy;
  logic cmd_wr, is_abort, new_cmd, refuse, wp_stop, start_ok;
  logic is_wr_cls, pos_done, pos_fail, xfer_done, wt_lost, wt_start;
  logic wt_done, finish, tick, ev_hit, clr_irq, data_wr;
  logic [3:0] nib;

  // status class of a new command
  function automatic dcs_cls_e cls_of(input logic [7:0] c);
    if (!c[CMD_XFER_BIT]) begin
      return CLS_POS;
    end else if (c[7:4] == CMD_WR_TRK) begin
      return CLS_WTRK;
    end else if (c[7:4] == CMD_RD_TRK) begin
      return CLS_RTRK;
    end else if (c[7:4] == CMD_RD_ADDR) begin
      return CLS_RADDR;
    end else if (c[CMD_WSEC_BIT]) begin
      return CLS_WSEC;
    end
    return CLS_RSEC;
  endfunction

  // ==========================================================
  // input edges
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      idx_prev_n <= 1'b1;
      rdy_prev <= 1'b0;
    end else begin
      idx_prev_n <= i_index_pulse_input_n;
      rdy_prev <= i_ready;
    end
  end

  // event and command decode
  assign idx_edge = idx_prev_n & ~i_index_pulse_input_n;
  assign rdy_rise = ~rdy_prev & i_ready;
  assign rdy_fall = rdy_prev & ~i_ready;
  assign busy = (state != S_IDLE);
  assign nib = i_wdata[7:4];
  assign cmd_wr = i_wr && i_addr == ADDR_CMD;
  assign data_wr = i_wr && i_addr == ADDR_DATA;
  assign is_abort = cmd_wr && nib == CMD_ABORT;
  assign new_cmd = cmd_wr && nib != CMD_ABORT && !busy;
  assign is_wr_cls = cls_of(i_wdata) == CLS_WSEC ||
                     cls_of(i_wdata) == CLS_WTRK;
  assign refuse = new_cmd && i_wdata[CMD_XFER_BIT] && !i_ready;
  assign wp_stop = new_cmd && is_wr_cls && i_ready &&
                   !i_write_protect_input_n;
  assign start_ok = new_cmd && !refuse && !wp_stop;
  assign pos_done = state == S_POS &&
                    (!pos_verify || (o_head_load_output &&
                     i_head_settle_input));
  assign pos_fail = state == S_POS && !pos_done && idx_edge && idx_seen;
  assign xfer_done = state == S_XFER && idx_edge && idx_seen;
  assign wt_lost = state == S_WT_WAIT && idx_edge && !dr_full;
  assign wt_start = state == S_WT_WAIT && idx_edge && dr_full;
  assign wt_done = state == S_WT_RUN && idx_edge;
  assign finish = pos_done || pos_fail || xfer_done || wt_lost ||
                  wt_done;
  assign tick = state == S_WT_RUN && !idx_edge && byte_cnt == '0;

  // ==========================================================
  // command sequencing
  always_ff @(posedge i_mclk) begin
    if (i_rst || is_abort) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_ok) begin
            if (!i_wdata[CMD_XFER_BIT]) begin
              state <= S_POS;
            end else if (nib == CMD_WR_TRK) begin
              state <= S_WT_WAIT;
            end else begin
              state <= S_XFER;
            end
          end
        end
        S_POS: begin
          if (pos_done || pos_fail) begin
            state <= S_IDLE;
          end
        end
        S_XFER: begin
          if (xfer_done) begin
            state <= S_IDLE;
          end
        end
        S_WT_WAIT: begin
          if (wt_lost) begin
            state <= S_IDLE;
          end else if (wt_start) begin
            state <= S_WT_RUN;
          end
        end
        S_WT_RUN: begin
          if (wt_done) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // index counting and verify flag per command
  always_ff @(posedge i_mclk) begin
    if (i_rst || new_cmd) begin
      idx_seen <= 1'b0;
      pos_verify <= i_rst ? 1'b0 : i_wdata[CMD_VERIFY_BIT];
    end else if (idx_edge) begin
      idx_seen <= 1'b1;
    end
  end

  // head load follows command
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_head_load_output <= 1'b0;
    end else if (start_ok) begin
      o_head_load_output <= i_wdata[CMD_XFER_BIT] |
                            i_wdata[CMD_HLOAD_BIT];
    end
  end

  // ==========================================================
  // stored status bits
  always_ff @(posedge i_mclk) begin
    if (i_rst || new_cmd || (is_abort && !busy)) begin
      seek_err <= 1'b0;
      crc_err <= 1'b0;
      rnf <= 1'b0;
      lost <= 1'b0;
      wfault <= 1'b0;
      wp_lat <= wp_stop;
      cls <= new_cmd ? cls_of(i_wdata) : CLS_POS;
    end else if (!is_abort) begin
      if (pos_fail) begin
        seek_err <= 1'b1;
      end
      if (xfer_done && cls != CLS_RTRK) begin
        rnf <= 1'b1;
      end
      if (i_crc_fault && (state == S_XFER || state == S_POS)) begin
        crc_err <= 1'b1;
      end
      if (i_write_fault && state == S_WT_RUN) begin
        wfault <= 1'b1;
      end
      if (wt_lost || (tick && !crc_lo_next && !dr_full)) begin
        lost <= 1'b1;
      end
    end
  end

  // ==========================================================
  // holding register and byte request
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dr <= DATA_RST;
      dr_full <= 1'b0;
      o_byte_transfer_request <= 1'b0;
    end else begin
      if (new_cmd) begin
        // request at once for write track
        dr_full <= 1'b0;
        o_byte_transfer_request <= start_ok && nib == CMD_WR_TRK;
      end else if (finish) begin
        o_byte_transfer_request <= 1'b0;
      end else if (tick && !crc_lo_next) begin
        dr_full <= 1'b0;
        o_byte_transfer_request <= 1'b1;
      end
      if (data_wr) begin
        dr <= i_wdata;
        dr_full <= 1'b1;
        o_byte_transfer_request <= 1'b0;
      end
    end
  end

  // ==========================================================
  // byte slot timer and write gate
  always_ff @(posedge i_mclk) begin
    if (i_rst || !busy) begin
      byte_cnt <= '0;
      crc_lo_next <= 1'b0;
      o_write_gate <= 1'b0;
    end else if (is_abort || wt_done) begin
      o_write_gate <= 1'b0;
    end else if (wt_start) begin
      byte_cnt <= '0;
      o_write_gate <= 1'b1;
    end else if (tick) begin
      byte_cnt <= i_density_select ? CNT_W'(BYTE_CYC_FM - 1) :
                                     CNT_W'(BYTE_CYC_MFM - 1);
      crc_lo_next <= !crc_lo_next && dr_full && dr == TB_CRC;
    end else if (state == S_WT_RUN) begin
      byte_cnt <= byte_cnt - 1'b1;
    end
  end

  // encoder feed; host keeps f5..fe out of plain contents
  assign enc.stb = tick;
  assign enc.fm = i_density_select;
  assign enc.crc_lo = crc_lo_next;
  // contents trusted to avoid control codes
  assign enc.raw = dr_full ? dr : FILL_BYTE;

  dcs_trk_enc u_enc (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .e(enc)
  );

  // encoded byte valid, aligned with encoder outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wr_strobe <= 1'b0;
    end else begin
      o_wr_strobe <= tick;
    end
  end

  assign o_wr_data = enc.wdat;
  assign o_wr_clk = enc.wclk;
  assign o_wr_miss = enc.miss;

  // ==========================================================
  // interrupt and abort conditions
  // condition per bit
  assign ev_hit = (arm[AB_TO_READY] & rdy_rise) |
                  (arm[AB_TO_NRDY] & rdy_fall) |
                  (arm[AB_INDEX] & idx_edge);
  assign clr_irq = cmd_wr || (i_rd && i_addr == ADDR_CMD);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      arm <= 3'h0;
      imm_pend <= 1'b0;
    end else if (is_abort) begin
      arm <= i_wdata[AB_INDEX:AB_TO_READY];
      imm_pend <= i_wdata[AB_IMM];
    end else if (new_cmd) begin
      arm <= 3'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_intrq <= 1'b0;
    end else if ((finish && !is_abort) || refuse || wp_stop ||
                 (ev_hit && !is_abort) || (is_abort && i_wdata[AB_IMM])) begin
      o_intrq <= 1'b1;
    end else if (clr_irq && (!imm_pend || is_abort)) begin
      o_intrq <= 1'b0;
    end
  end

  // ==========================================================
  // status composition
  // not ready with reset
  assign nrdy = ~i_ready | i_rst;

  always_comb begin
    status_now = STATUS_RST;
    unique case (cls)
      CLS_POS: begin
        status_now = {nrdy, ~i_write_protect_input_n,
                      o_head_load_output & i_head_settle_input,
                      seek_err, crc_err, ~i_track_zero_input_n,
                      ~i_index_pulse_input_n, busy};
      end
      CLS_RADDR, CLS_RSEC: begin
        // read layout, record type not tracked
        status_now = {nrdy, 2'b00, rnf, crc_err, lost,
                      o_byte_transfer_request, busy};
      end
      CLS_RTRK: begin
        status_now = {nrdy, 4'h0, lost, o_byte_transfer_request, busy};
      end
      CLS_WSEC: begin
        status_now = {nrdy, wp_lat, wfault, rnf, crc_err, lost,
                      o_byte_transfer_request, busy};
      end
      CLS_WTRK: begin
        status_now = {nrdy, wp_lat, wfault, 2'b00, lost,
                      o_byte_transfer_request, busy};
      end
      default: status_now = STATUS_RST;
    endcase
  end

  // ==========================================================
  // register read port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= STATUS_RST;
    end else if (i_rd && i_addr == ADDR_CMD) begin
      o_rdata <= status_now;
    end else if (i_rd && i_addr == ADDR_DATA) begin
      o_rdata <= dr;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// ---- test/dcs_ctrl_sva.sv ----
// port checker of the disk status and format block
`timescale 1ns/10ps
module dcs_ctrl_chk #(
  parameter int BYTE_CYC_FM = 800, // fm byte time
  parameter int BYTE_CYC_MFM = 400 // mfm byte time
) (
  input wire logic i_mclk, // clock
  input wire logic i_rst, // reset
  input wire logic [dcs_pkg::ADDR_W-1:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic i_ready, // drive ready
  input wire logic i_write_protect_input_n, // protect
  input wire logic i_density_select, // density
  input wire logic o_intrq, // interrupt
  input wire logic o_byte_transfer_request, // request
  input wire logic o_head_load_output, // head load
  input wire logic o_write_gate, // gate
  input wire logic o_wr_strobe, // byte strobe
  input wire logic [7:0] o_wr_data, // byte
  input wire logic o_wr_miss // missing clock
);
  import dcs_pkg::*;
  logic cmd_wr; // command write
  logic abort_wr; // abort write
  logic imm; // immediate interrupt pending
  // decode of command writes
  assign cmd_wr = i_wr && i_addr == ADDR_CMD;
  assign abort_wr = cmd_wr && i_wdata[7:4] == CMD_ABORT;
  // pending immediate interrupt, only an abort changes it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      imm <= 1'b0;
    end else if (abort_wr) begin
      imm <= i_wdata[AB_IMM];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  chk_nrdy_bit: assert property (
    i_rd && i_addr == ADDR_CMD && $stable(i_ready)
    |=> o_rdata[7] == !$past(i_ready)) else $error("not ready bit wrong");
  chk_imm_raise: assert property (
    abort_wr && i_wdata[AB_IMM] |=> o_intrq) else $error("no immediate irq");
  chk_imm_hold: assert property (
    imm && !abort_wr |=> o_intrq) else $error("immediate irq lost");
  chk_abort_quiet: assert property (
    abort_wr && i_wdata[3:0] == 4'h0 |=> !o_intrq) else $error("quiet abort");
  chk_refuse_nrdy: assert property (
    cmd_wr && i_wdata[7] && !abort_wr && !i_ready |=> o_intrq [*2])
    else $error("refusal without irq");
  chk_wtrk_start: assert property (
    cmd_wr && i_wdata[7:4] == CMD_WR_TRK && i_ready && i_write_protect_input_n
    |=> o_byte_transfer_request && o_head_load_output)
    else $error("no request at track start");
  chk_strobe_gate: assert property (
    o_wr_strobe |-> o_write_gate || $past(o_write_gate))
    else $error("byte outside gate");
  chk_mfm_miss: assert property (
    o_wr_strobe && o_wr_miss |-> !i_density_select
    && (o_wr_data == MARK_A1 || o_wr_data == MARK_C2))
    else $error("bad missing clock mark");
endmodule
bind dcs_ctrl dcs_ctrl_chk #(.BYTE_CYC_FM(BYTE_CYC_FM),
  .BYTE_CYC_MFM(BYTE_CYC_MFM)) i_dcs_ctrl_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ready(i_ready),
  .i_write_protect_input_n(i_write_protect_input_n),
  .i_density_select(i_density_select), .o_intrq(o_intrq),
  .o_byte_transfer_request(o_byte_transfer_request),
  .o_head_load_output(o_head_load_output), .o_write_gate(o_write_gate),
  .o_wr_strobe(o_wr_strobe), .o_wr_data(o_wr_data), .o_wr_miss(o_wr_miss));

// ---- test/dcs_drive_model.sv ----
// drive model: index pulses and head settle delay
`timescale 1ns/10ps
module dcs_drive_model #(
  parameter int IDX_PERIOD = 240, // cycles per turn
  parameter int SETTLE_CYC = 5 // head settle delay
) (
  input wire logic i_mclk, // clock
  input wire logic i_spin, // spindle on
  input wire logic i_head_load_output, // head load
  output logic o_index_pulse_input_n, // index, low
  output logic o_head_settle_input // head settled
);
  logic [15:0] turn; // position in the turn
  logic [7:0] settle; // cycles since head load
  // rotation counter, parked while stopped
  always_ff @(posedge i_mclk) begin
    if (!i_spin || turn == 16'(IDX_PERIOD - 1)) begin
      turn <= 16'h0000;
    end else begin
      turn <= turn + 16'h0001;
    end
  end
  // settle timer restarts whenever the head lifts
  always_ff @(posedge i_mclk) begin
    if (!i_head_load_output) begin
      settle <= 8'h00;
    end else if (settle != 8'(SETTLE_CYC)) begin
      settle <= settle + 8'h01;
    end
  end
  // index low four cycles a turn, idle high when stopped
  assign o_index_pulse_input_n = !(i_spin && turn < 16'h0004);
  assign o_head_settle_input = settle == 8'(SETTLE_CYC);
endmodule

// ---- test/testbench.sv ----
// self-checking bench of the disk status and format block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module testbench;
  import dcs_pkg::*;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ready = 1'b1;
  logic i_wp_n = 1'b0;
  logic i_trk0_n = 1'b0;
  logic i_fm = 1'b1;
  logic i_spin = 1'b0;
  logic i_idx_n, i_settle, o_intrq, o_drq, o_hld, o_gate, o_stb, o_miss;
  logic [7:0] o_rdata, o_wdat, o_wclk;
  logic [7:0] got[$];
  logic [8:0] gx[$];
  dcs_ctrl #(.BYTE_CYC_FM(8), .BYTE_CYC_MFM(4)) i_dcs_ctrl (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ready(i_ready),
    .i_write_protect_input_n(i_wp_n), .i_head_settle_input(i_settle),
    .i_track_zero_input_n(i_trk0_n), .i_index_pulse_input_n(i_idx_n),
    .i_density_select(i_fm), .i_crc_fault(1'b0), .i_write_fault(1'b0),
    .o_intrq(o_intrq), .o_byte_transfer_request(o_drq),
    .o_head_load_output(o_hld), .o_write_gate(o_gate), .o_wr_strobe(o_stb),
    .o_wr_data(o_wdat), .o_wr_clk(o_wclk), .o_wr_miss(o_miss));
  dcs_drive_model i_dcs_drive_model (.i_mclk(i_mclk), .i_spin(i_spin),
    .i_head_load_output(o_hld), .o_index_pulse_input_n(i_idx_n),
    .o_head_settle_input(i_settle));
  // free running clock
  always #20 i_mclk = ~i_mclk;
  // hang guard and capture of written bytes
  always @(posedge i_mclk) begin
    cycles++;
    if (o_stb === 1'b1) begin
      got.push_back(o_wdat);
      gx.push_back({o_miss, o_wclk});
    end
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
    @(posedge i_mclk);
  endtask
  task automatic cki(input logic ex);
    @(negedge i_mclk);
    `CHK("interrupt", ex, o_intrq);
    @(posedge i_mclk);
  endtask
  // bounded wait for the request (1) or the interrupt (0)
  task automatic wait_for(input bit byte_transfer_request);
    int n;
    n = 0;
    @(negedge i_mclk);
    while ((byte_transfer_request ? o_drq : o_intrq) !== 1'b1 && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    if (n == 3000) mismatches++;
    @(posedge i_mclk);
  endtask
  function automatic logic [15:0] crc_add(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  // format one track, then stop feeding so zero fill and lost data show
  task automatic wtrk(input logic fm, input logic [7:0] b[$]);
    logic [7:0] ex[$];
    logic [7:0] v;
    logic [7:0] st;
    logic [15:0] c;
    logic [8:0] mk;
    c = CRC_PRESET;
    mk = fm ? {1'b0, CLK_AM} : {1'b1, CLK_NORM};
    foreach (b[k]) begin
      v = (!fm && b[k] == TB_A1M) ? MARK_A1 : b[k];
      v = (!fm && b[k] == TB_C2M) ? MARK_C2 : v;
      if (fm ? (b[k] == TB_IDAM || (b[k] >= TB_DAM_LO && b[k] <= TB_DAM_HI))
          : b[k] == TB_A1M) c = CRC_PRESET;
      if (b[k] == TB_CRC) begin
        ex.push_back(c[15:8]);
        ex.push_back(c[7:0]);
      end else begin
        c = crc_add(c, v);
        ex.push_back(v);
      end
    end
    ex.push_back(FILL_BYTE);
    i_fm <= fm;
    @(posedge i_mclk);
    got.delete();
    gx.delete();
    wr(ADDR_CMD, {CMD_WR_TRK, 4'h0});
    foreach (b[k]) begin
      wait_for(1'b1);
      wr(ADDR_DATA, b[k]);
      i_spin <= 1'b1;
    end
    wait_for(1'b0);
    i_spin <= 1'b0;
    rd(ADDR_CMD, st);
    `CHK("track status", 8'h04, st);
    foreach (ex[k]) `CHK("track byte", ex[k], got[k]);
    `CHK("mark clock", mk, gx[0]);
  endtask
  // main sequence
  initial begin
    logic [7:0] st;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(ADDR_CMD, st);
    `CHK("reset status", 8'h44, st);
    rd(2'h3, st);
    `CHK("unmapped read", 8'h00, st);
    wr(ADDR_CMD, 8'h0c);
    wait_for(1'b0);
    rd(ADDR_CMD, st);
    `CHK("seek status", 8'h64, st);
    wr(ADDR_CMD, {CMD_RD_TRK, 4'h0});
    @(posedge i_mclk);
    wr(ADDR_CMD, 8'hd0);
    rd(ADDR_CMD, st);
    `CHK("abort busy", 8'h00, st);
    wr(ADDR_CMD, 8'hd0);
    rd(ADDR_CMD, st);
    `CHK("abort idle", 8'h44, st & 8'hdf);
    wr(ADDR_CMD, 8'hd8);
    cki(1'b1);
    rd(ADDR_CMD, st);
    cki(1'b1);
    wr(ADDR_CMD, 8'hd0);
    cki(1'b0);
    wr(ADDR_CMD, 8'hd1);
    i_ready <= 1'b0;
    repeat (4) @(posedge i_mclk);
    cki(1'b0);
    rd(ADDR_CMD, st);
    `CHK("not ready bit", 1'b1, st[7]);
    i_ready <= 1'b1;
    repeat (4) @(posedge i_mclk);
    cki(1'b1);
    wr(ADDR_CMD, 8'hd2);
    i_ready <= 1'b0;
    repeat (4) @(posedge i_mclk);
    cki(1'b1);
    rd(ADDR_CMD, st);
    wr(ADDR_CMD, 8'h80);
    cki(1'b1);
    rd(ADDR_CMD, st);
    `CHK("refused busy", 1'b0, st[0]);
    i_ready <= 1'b1;
    wr(ADDR_CMD, 8'hd4);
    i_spin <= 1'b1;
    wait_for(1'b0);
    cki(1'b1);
    wr(ADDR_CMD, 8'hd0);
    i_spin <= 1'b0;
    i_wp_n <= 1'b1;
    wtrk(1'b1, '{8'hfe, 8'h01, 8'h02, 8'hf7, 8'h4e});
    wtrk(1'b0, '{8'hf5, 8'hf6, 8'h01, 8'hf7, 8'h4e});
    summarize();
  end
endmodule
